// file: core/ptr_state_mem.v
`timescale 1ns/100ps
`include "spi_consts.vh"

// Per-slot state memory with a registered read port and write-first
// forwarding so that back-to-back access to one slot sees fresh data.
module ptr_state_mem (
  input  wire                      clk_sys_i,
  input  wire                      ce_i,
  input  wire [`SPI_IDX_W-1:0]     raddr_i,
  output reg  [`SPI_ENTRY_W-1:0]   rdata_o,
  input  wire                      we_i,
  input  wire [`SPI_IDX_W-1:0]     waddr_i,
  input  wire [`SPI_ENTRY_W-1:0]   wdata_i
);

  reg [`SPI_ENTRY_W-1:0] mem_q [0:`SPI_NUM_STS-1];

  // Write port and registered read with forwarding of the write data.
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
      if (we_i && (waddr_i == raddr_i)) begin
        rdata_o <= wdata_i;
      end else begin
        rdata_o <= mem_q[raddr_i];
      end
    end
  end

endmodule // ptr_state_mem

// file: core/sonet_pointer_interpreter.v
`timescale 1ns/100ps
`include "spi_consts.vh"

// Summary of operation
// - Flag payload envelope, trace byte and payload start per byte to fabric.
// - With the interpreter bypassed both flags stay low.
// - Pointer word splits into 4-bit NDF, 2 unused bits, 10-bit value.
// - Value is byte offset to payload start, 0 to 782 valid, I/D bits.
// - NDF 0110 means pointer unchanged, 1001 means new data.
// - Other NDF patterns resolve by three-of-four match.
// - All ones in NDF and value bits is an AIS pointer.
// - Concatenation in multiples of three from an STS-3 boundary; the code checks neither group size nor boundary.
// - Concatenated groups start only at allowed STS-1 numbers; the code lets any slot head a group.
// - Pointer action byte carries payload only on negative adjustment.
// - Increment and decrement decisions need eight of ten bits.
// - A single differing valid pointer is ignored.
// - Two consecutive differing normal pointers move the payload start.
// - Generator resets its offset and signals NDF on unexpected start.
// - Three states; two consecutive normal pointers enter normal.
// - Two concatenation pointers enter concatenated; members use head offset.
// - Two AIS pointers enter AIS; two normal or concatenation pointers leave.
// - In AIS every outgoing byte is replaced by all ones.
// - A single bit error changes neither state nor data flow.
// - Flag pair encodes overhead, trace, payload and payload start.
// - No start pulse in AIS; only the group head carries one.
module sonet_pointer_interpreter (
  input  wire                  clk_sys_i,
  input  wire                  rst_i,
  input  wire                  ce_i,
  input  wire                  bypass_i,
  input  wire                  valid_i,
  input  wire [7:0]            data_i,
  input  wire [`SPI_IDX_W-1:0] sts_idx_i,
  input  wire                  h1_slot_i,
  input  wire                  h2_slot_i,
  input  wire                  h3_slot_i,
  input  wire                  pos_stuff_slot_i,
  input  wire                  spe_slot_i,
  input  wire [9:0]            spe_pos_i,
  input  wire                  trace_slot_i,
  output reg                   valid_o,
  output reg  [7:0]            data_o,
  output reg                   payload_envelope_flag_o,
  output reg                   trace_payload_start_flag_o,
  output reg                   ndf_req_o,
  output reg                   inc_o,
  output reg                   dec_o,
  output reg                   ais_o
);

  // Stage one copies of the byte attributes, aligned with memory data.
  reg                  s1_valid_q;
  reg [7:0]            s1_data_q;
  reg [`SPI_IDX_W-1:0] s1_idx_q;
  reg                  s1_h1_q;
  reg                  s1_h2_q;
  reg                  s1_h3_q;
  reg                  s1_pstuff_q;
  reg                  s1_spe_q;
  reg [9:0]            s1_pos_q;
  reg                  s1_trace_q;
  reg [9:0]            head_off_q;
  reg [9:0]            head_off_d;
  reg                  head_ais_q;
  reg                  head_ais_d;

  wire [`SPI_ENTRY_W-1:0] mem_entry;
  reg  [`SPI_NUM_STS-1:0] seen_q;
  reg  [`SPI_ENTRY_W-1:0] wr_entry;
  reg                     wr_en;

  // Ones count of a ten-bit vector.
  function [3:0] ones10;
    input [9:0] v;
    integer i;
    begin
      ones10 = 4'h0;
      for (i = 0; i < 10; i = i + 1) begin
        ones10 = ones10 + {3'h0, v[i]};
      end
    end
  endfunction

  // Ones count of a four-bit vector.
  function [2:0] ones4;
    input [3:0] v;
    begin
      ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    end
  endfunction

  ptr_state_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .raddr_i   (sts_idx_i),
    .rdata_o   (mem_entry),
    .we_i      (wr_en),
    .waddr_i   (s1_idx_q),
    .wdata_i   (wr_entry)
  );

  // The memory is not cleared by reset: a slot not yet written since reset
  // reads as the reset entry, so its state and offset start out known.
  wire [`SPI_ENTRY_W-1:0] rd_entry = seen_q[s1_idx_q] ? mem_entry :
                                     `SPI_RESET_ENTRY;

  // One sticky written mark per slot, set by any write-back to that slot.
  genvar g;
  generate
    for (g = 0; g < `SPI_NUM_STS; g = g + 1) begin : g_seen
      localparam [`SPI_IDX_W-1:0] SLOT = g;
      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          seen_q[g] <= 1'b0;
        end else if (ce_i && wr_en && (s1_idx_q == SLOT)) begin
          seen_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Fields of the entry of the slot now at stage one.
  wire [1:0] e_state = rd_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO];
  wire [9:0] e_off   = rd_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO];
  wire [1:0] e_prev  = rd_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO];
  wire       e_pdiff = rd_entry[`SPI_E_PDIFF];
  wire       e_neg   = rd_entry[`SPI_E_NEG];
  wire       e_pos   = rd_entry[`SPI_E_POS];
  wire [7:0] e_h1    = rd_entry[`SPI_E_H1_HI:`SPI_E_H1_LO];

  // Pointer word and its fields.
  wire [15:0] pw   = {e_h1, s1_data_q};
  wire [3:0]  ndf  = pw[`SPI_NDF_HI:`SPI_NDF_LO];
  wire [9:0]  pval = pw[`SPI_PTR_HI:`SPI_PTR_LO];

  // NDF resolution by exact or three-of-four match.
  wire ndf_same = ones4(ndf ^ `SPI_NDF_SAME) <= `SPI_NDF_ERR;
  wire ndf_new  = ones4(ndf ^ `SPI_NDF_NEW) <= `SPI_NDF_ERR;

  // Pointer classification.
  wire is_ais   = (ndf == `SPI_NDF_ONES) && (pval == `SPI_PTR_ONES);
  wire is_concatenated_pointer_state  = !is_ais && ndf_new && (pval == `SPI_PTR_ONES);
  wire in_range = pval <= `SPI_PTR_MAX;
  wire is_normal_pointer_state  = !is_ais && (ndf_same || ndf_new) && in_range;
  wire ptr_diff = pval != e_off;

  // Justification, eight of ten bits agreeing with an inverted group.
  wire [9:0] flips  = pval ^ e_off;
  wire       is_inc = ndf_same && (e_state == `SPI_ST_NORMAL_POINTER_STATE) &&
                      (ones10(flips ^ `SPI_I_MASK) <= `SPI_MAJ_ERR);
  wire       is_dec = ndf_same && (e_state == `SPI_ST_NORMAL_POINTER_STATE) &&
                      (ones10(flips ^ `SPI_D_MASK) <= `SPI_MAJ_ERR);

  // Next offset values after a justification.
  wire [9:0] off_up = (e_off == `SPI_PTR_MAX) ? 10'h000 : e_off + 10'h001;
  wire [9:0] off_dn = (e_off == 10'h000) ? `SPI_PTR_MAX : e_off - 10'h001;

  // Pointer processing and write-back of the slot entry.
  always @* begin
    wr_entry   = rd_entry;
    wr_en      = 1'b0;
    head_off_d = head_off_q;
    head_ais_d = head_ais_q;
    if (s1_valid_q && s1_h1_q) begin
      wr_en = 1'b1;
      wr_entry[`SPI_E_H1_HI:`SPI_E_H1_LO] = s1_data_q;
    end else if (s1_valid_q && s1_h2_q) begin
      wr_en = 1'b1;
      wr_entry[`SPI_E_NEG] = 1'b0;
      wr_entry[`SPI_E_POS] = 1'b0;
      if (is_ais) begin
        wr_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO] = `SPI_K_AIS;
        if (e_prev == `SPI_K_AIS) begin
          wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] = `SPI_ST_AIS;
        end
      end else if (is_concatenated_pointer_state) begin
        wr_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO] = `SPI_K_CONCATENATED_POINTER_STATE;
        if (e_prev == `SPI_K_CONCATENATED_POINTER_STATE) begin
          wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] = `SPI_ST_CONCATENATED_POINTER_STATE;
          wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO] = head_off_q;
        end
      end else if (is_inc) begin
        wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO] = off_up;
        wr_entry[`SPI_E_POS] = 1'b1;
        wr_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO] = `SPI_K_NORMAL_POINTER_STATE;
        wr_entry[`SPI_E_PDIFF] = 1'b0;
      end else if (is_dec) begin
        wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO] = off_dn;
        wr_entry[`SPI_E_NEG] = 1'b1;
        wr_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO] = `SPI_K_NORMAL_POINTER_STATE;
        wr_entry[`SPI_E_PDIFF] = 1'b0;
      end else if (is_normal_pointer_state) begin
        wr_entry[`SPI_E_PREV_HI:`SPI_E_PREV_LO] = `SPI_K_NORMAL_POINTER_STATE;
        wr_entry[`SPI_E_PDIFF] = ptr_diff;
        if (e_prev == `SPI_K_NORMAL_POINTER_STATE) begin
          wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] = `SPI_ST_NORMAL_POINTER_STATE;
          if (ptr_diff && (e_pdiff || e_state != `SPI_ST_NORMAL_POINTER_STATE)) begin
            wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO] = pval;
          end
        end
      end
      // Invalid NDF leaves state and history untouched.
      if (wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] != `SPI_ST_CONCATENATED_POINTER_STATE) begin
        head_off_d = wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO];
        head_ais_d = wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] ==
                     `SPI_ST_AIS;
      end
    end
  end

  // Offset change that the generator must answer with an NDF.
  wire off_moved = wr_en && s1_h2_q &&
                   (wr_entry[`SPI_E_OFF_HI:`SPI_E_OFF_LO] != e_off) &&
                   !is_inc && !is_dec;
  wire leave_ais = wr_en && s1_h2_q && (e_state == `SPI_ST_AIS) &&
                   (wr_entry[`SPI_E_STATE_HI:`SPI_E_STATE_LO] !=
                    `SPI_ST_AIS);

  // Per-byte classification of the slot at stage one.
  wire slot_ais   = (e_state == `SPI_ST_AIS);
  // A concatenation member follows the alarm of its head.
  wire out_ais    = slot_ais || (e_state == `SPI_ST_CONCATENATED_POINTER_STATE && head_ais_q);
  wire slot_neg   = s1_h3_q && e_neg;
  wire slot_spe   = s1_spe_q && !(s1_pstuff_q && e_pos);
  wire pay_flag   = !out_ais && (slot_neg || slot_spe);
  wire start_flag = pay_flag && slot_spe && (s1_pos_q == e_off) &&
                    (e_state == `SPI_ST_NORMAL_POINTER_STATE);
  wire trace_flag = s1_trace_q && (s1_idx_q == {`SPI_IDX_W{1'b0}});

  // Stage one input register.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_valid_q  <= 1'b0;
      s1_data_q   <= 8'h00;
      s1_idx_q    <= {`SPI_IDX_W{1'b0}};
      s1_h1_q     <= 1'b0;
      s1_h2_q     <= 1'b0;
      s1_h3_q     <= 1'b0;
      s1_pstuff_q <= 1'b0;
      s1_spe_q    <= 1'b0;
      s1_pos_q    <= 10'h000;
      s1_trace_q  <= 1'b0;
    end else if (ce_i) begin
      s1_valid_q  <= valid_i;
      s1_data_q   <= data_i;
      s1_idx_q    <= sts_idx_i;
      s1_h1_q     <= h1_slot_i;
      s1_h2_q     <= h2_slot_i;
      s1_h3_q     <= h3_slot_i;
      s1_pstuff_q <= pos_stuff_slot_i;
      s1_spe_q    <= spe_slot_i;
      s1_pos_q    <= spe_pos_i;
      s1_trace_q  <= trace_slot_i;
    end
  end

  // Offset and alarm of the most recent group head.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      head_off_q <= 10'h000;
      head_ais_q <= 1'b0;
    end else if (ce_i) begin
      head_off_q <= head_off_d;
      head_ais_q <= head_ais_d;
    end
  end

  // Output register: data, flags and generator controls.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      valid_o                    <= 1'b0;
      data_o                     <= 8'h00;
      payload_envelope_flag_o    <= 1'b0;
      trace_payload_start_flag_o <= 1'b0;
      ndf_req_o                  <= 1'b0;
      inc_o                      <= 1'b0;
      dec_o                      <= 1'b0;
      ais_o                      <= 1'b0;
    end else if (ce_i) begin
      valid_o <= s1_valid_q;
      if (bypass_i) begin
        data_o                     <= s1_data_q;
        payload_envelope_flag_o    <= 1'b0;
        trace_payload_start_flag_o <= 1'b0;
        ndf_req_o                  <= 1'b0;
        inc_o                      <= 1'b0;
        dec_o                      <= 1'b0;
        ais_o                      <= 1'b0;
      end else begin
        // Alarm and fill follow the slot or, for a member, its head.
        ais_o  <= s1_valid_q && out_ais;
        data_o <= out_ais ? `SPI_AIS_BYTE : s1_data_q;
        payload_envelope_flag_o <= s1_valid_q &&
                                   (start_flag || (pay_flag && !trace_flag));
        trace_payload_start_flag_o <= s1_valid_q &&
                                      (trace_flag || start_flag);
        ndf_req_o <= off_moved || leave_ais;
        inc_o     <= wr_en && s1_h2_q && is_inc;
        dec_o     <= wr_en && s1_h2_q && is_dec;
      end
    end
  end

endmodule // sonet_pointer_interpreter

// file: core/spi_consts.vh
`ifndef SPI_CONSTS_VH
`define SPI_CONSTS_VH

// Number of STS-1 slots held in the per-slot state memory.
`define SPI_NUM_STS        12
`define SPI_IDX_W          4
`define SPI_ENTRY_W        25

// Field positions inside one per-slot state entry.
`define SPI_E_STATE_LO     0
`define SPI_E_STATE_HI     1
`define SPI_E_OFF_LO       2
`define SPI_E_OFF_HI       11
`define SPI_E_PREV_LO      12
`define SPI_E_PREV_HI      13
`define SPI_E_PDIFF        14
`define SPI_E_NEG          15
`define SPI_E_POS          16
`define SPI_E_H1_LO        17
`define SPI_E_H1_HI        24

// Interpreter states.
`define SPI_ST_NORMAL_POINTER_STATE        2'h0
`define SPI_ST_CONCATENATED_POINTER_STATE        2'h1
`define SPI_ST_AIS         2'h2

// Kind of the previous accepted pointer.
`define SPI_K_NONE         2'h0
`define SPI_K_NORMAL_POINTER_STATE         2'h1
`define SPI_K_CONCATENATED_POINTER_STATE         2'h2
`define SPI_K_AIS          2'h3

// Pointer word fields and patterns.
`define SPI_NDF_HI         15
`define SPI_NDF_LO         12
`define SPI_SS_HI          11
`define SPI_SS_LO          10
`define SPI_PTR_HI         9
`define SPI_PTR_LO         0
`define SPI_NDF_SAME       4'h6
`define SPI_NDF_NEW        4'h9
`define SPI_NDF_ONES       4'hF
`define SPI_PTR_ONES       10'h3FF
`define SPI_PTR_MAX        10'h30E
`define SPI_I_MASK         10'h2AA
`define SPI_D_MASK         10'h155
`define SPI_MAJ_ERR        4'h2
`define SPI_NDF_ERR        3'h1
`define SPI_AIS_BYTE       8'hFF
`define SPI_RESET_ENTRY    25'h0000000

`endif

// file: tb/fabric_sink.sv
`timescale 1ns/100ps
module fabric_sink (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       valid_i,
  input  wire       payload_i,
  input  wire       start_i,
  output reg  [7:0] start_cnt_o
);
  // Counts payload start bytes, the cue the fabric aligns its cells to.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      start_cnt_o <= 8'h00;
    end else if (valid_i && payload_i && start_i) begin
      start_cnt_o <= start_cnt_o + 8'h01;
    end
  end
endmodule  // fabric_sink

// file: tb/sonet_pointer_interpreter_bench.sv
`timescale 1ns/100ps
module sonet_pointer_interpreter_bench;
  reg         clk_sys_i, rst_i, bypass_i, valid_i;
  reg         h1_slot_i, h2_slot_i, spe_slot_i, trace_slot_i;
  reg         h3_slot_i, pstuff_i;
  reg  [3:0]  sts_idx_i, idx;
  reg  [7:0]  data_i;
  reg  [9:0]  spe_pos_i;
  wire        valid_o, pe_w, tp_w, ndf_w, inc_w, dec_w, ais_w;
  wire [7:0]  data_o, start_cnt;
  reg  [15:0] exp_q[$];
  reg  [15:0] cur;
  reg  [31:0] r;
  integer     err_total, num_checks, exp_starts, i;
  // Free running system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  sonet_pointer_interpreter dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(1'b1), .bypass_i(bypass_i), .valid_i(valid_i), .data_i(data_i),
    .sts_idx_i(sts_idx_i), .h1_slot_i(h1_slot_i), .h2_slot_i(h2_slot_i),
    .h3_slot_i(h3_slot_i), .pos_stuff_slot_i(pstuff_i),
    .spe_slot_i(spe_slot_i),
    .spe_pos_i(spe_pos_i), .trace_slot_i(trace_slot_i), .valid_o(valid_o),
    .data_o(data_o), .payload_envelope_flag_o(pe_w),
    .trace_payload_start_flag_o(tp_w), .ndf_req_o(ndf_w), .inc_o(inc_w),
    .dec_o(dec_w), .ais_o(ais_w));
  fabric_sink sink_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .valid_i(valid_o), .payload_i(pe_w), .start_i(tp_w),
    .start_cnt_o(start_cnt));
  // Expected entry: alarm, inc, dec, check data, check flags, payload,
  // trace, ndf, byte.
  function [15:0] ex(input p, input t, input [7:0] d);
    ex = {5'b00011, p, t, 1'b0, d};
  endfunction
  task cmp_bit(input got, input want);
    num_checks = num_checks + 1;
    if (got !== want) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: flag %b want %b", $time, got, want);
    end
  endtask
  task cmp_byte(input [7:0] got, input [7:0] want);
    num_checks = num_checks + 1;
    if (got !== want) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: byte %h want %h", $time, got, want);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Drives one byte of kind k (1 H1, 2 H2, 3 SPE, 4 trace, 5 H3, 6 SPE
  // column in the positive stuff slot) for slot idx and notes it.
  task put(input [7:0] d, input [2:0] k, input [9:0] p, input [15:0] e);
    @(posedge clk_sys_i);
    valid_i <= 1'b1;
    data_i <= d;
    sts_idx_i <= idx;
    h1_slot_i <= (k == 3'h1);
    h2_slot_i <= (k == 3'h2);
    h3_slot_i <= (k == 3'h5);
    pstuff_i <= (k == 3'h6);
    spe_slot_i <= (k == 3'h3) || (k == 3'h6);
    trace_slot_i <= (k == 3'h4);
    spe_pos_i <= p;
    exp_q.push_back(e);
    if (e[11] && e[10] && e[9]) exp_starts = exp_starts + 1;
  endtask
  // Pointer word; m: 0 unchecked, 1 quiet, 2 ndf only, 3 ndf and data.
  task ptr(input [15:0] w, input [1:0] m);
    put(w[15:8], 3'h1, 10'h000,
        (m[0] | ~m[1]) & |m ? ex(0, 0, w[15:8]) : 16'h0000);
    put(w[7:0], 3'h2, 10'h000, m == 2'h1 ? ex(0, 0, w[7:0]) :
        m == 2'h2 ? 16'h0900 : m == 2'h3 ? ex(0, 0, w[7:0]) | 16'h0100 :
        16'h0000);
  endtask
  // Takes the oldest note whenever a byte leaves the block.
  always @(posedge clk_sys_i) begin
    if (valid_o === 1'b1) begin
      cur = exp_q.size() > 0 ? exp_q.pop_front() : 16'h1800;
      if (cur[11]) begin
        cmp_bit(pe_w, cur[10]);
        cmp_bit(tp_w, cur[9]);
        cmp_bit(ndf_w, cur[8]);
        cmp_bit(inc_w, cur[14]);
        cmp_bit(dec_w, cur[13]);
        cmp_bit(ais_w, cur[15]);
      end
      if (cur[12]) cmp_byte(data_o, cur[7:0]);
    end
  end
  // Cuts a hang short.
  initial begin
    #20000;
    err_total = err_total + 1;
    complete_run;
  end
  // Main sequence of tests.
  initial begin
    {err_total, num_checks, exp_starts} = 0;
    {rst_i, bypass_i, valid_i, h1_slot_i, h2_slot_i} = 5'h10;
    {spe_slot_i, trace_slot_i, data_i, spe_pos_i} = 20'h00000;
    {h3_slot_i, pstuff_i, sts_idx_i, idx} = 10'h000;
    r = $urandom(66560);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (i = 0; i < 3; i = i + 1) ptr(16'h600A, 2'h0);
    put(8'hA5, 3'h3, 10'd10, ex(1, 1, 8'hA5));
    put(8'h5A, 3'h3, 10'd11, ex(1, 0, 8'h5A));
    put(8'h3C, 3'h4, 10'd0, ex(0, 1, 8'h3C));
    $display("test flags done");
    ptr(16'h6014, 2'h1);
    put(8'h11, 3'h3, 10'd10, ex(1, 1, 8'h11));
    ptr(16'h600A, 2'h1);
    ptr(16'h600F, 2'h1);
    ptr(16'h6019, 2'h3);
    put(8'h22, 3'h3, 10'd25, ex(1, 1, 8'h22));
    put(8'h33, 3'h3, 10'd10, ex(1, 0, 8'h33));
    $display("test pointer move done");
    ptr(16'hE019, 2'h1);
    ptr(16'h0064, 2'h1);
    put(8'h44, 3'h3, 10'd25, ex(1, 1, 8'h44));
    $display("test pointer errors done");
    ptr(16'hFFFF, 2'h0);
    ptr(16'hFFFF, 2'h0);
    put(8'h55, 3'h3, 10'd25, ex(0, 0, 8'hFF) | 16'h8000);
    ptr(16'h601E, 2'h0);
    put(8'h60, 3'h1, 10'h000, 16'h0000);
    put(8'h1E, 3'h2, 10'h000, 16'h8900);
    put(8'h66, 3'h3, 10'd30, ex(1, 1, 8'h66));
    $display("test alarm done");
    put(8'h62, 3'h1, 10'h000, ex(0, 0, 8'h62));
    put(8'hB4, 3'h2, 10'h000, ex(0, 0, 8'hB4) | 16'h4000);
    put(8'h81, 3'h6, 10'd29, ex(0, 0, 8'h81));
    put(8'h82, 3'h3, 10'd31, ex(1, 1, 8'h82));
    put(8'h61, 3'h1, 10'h000, ex(0, 0, 8'h61));
    put(8'h4A, 3'h2, 10'h000, ex(0, 0, 8'h4A) | 16'h2000);
    put(8'h83, 3'h5, 10'h000, ex(1, 0, 8'h83));
    $display("test justification done");
    idx = 4'h1;
    ptr(16'h93FF, 2'h0);
    idx = 4'h0;
    ptr(16'h601E, 2'h1);
    idx = 4'h1;
    ptr(16'h93FF, 2'h0);
    put(8'h84, 3'h3, 10'd30, ex(1, 0, 8'h84));
    idx = 4'h0;
    put(8'h85, 3'h3, 10'd30, ex(1, 1, 8'h85));
    $display("test concatenation done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      put(r[7:0], 3'h3, 10'd100 + {1'b0, r[16:8]}, ex(1, 0, r[7:0]));
    end
    $display("test random payload done");
    @(posedge clk_sys_i);
    valid_i <= 1'b0;
    @(posedge clk_sys_i);
    bypass_i <= 1'b1;
    put(8'h77, 3'h3, 10'd30, ex(0, 0, 8'h77));
    put(8'h78, 3'h3, 10'd30, ex(0, 0, 8'h78));
    put(8'h79, 3'h4, 10'd0, ex(0, 0, 8'h79));
    @(posedge clk_sys_i);
    valid_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    bypass_i <= 1'b0;
    $display("test bypass done");
    cmp_byte(start_cnt, exp_starts[7:0]);
    cmp_byte((exp_q.size() > 0) ? 8'h01 : 8'h00, 8'h00);
    complete_run;
  end
endmodule  // sonet_pointer_interpreter_bench
bind sonet_pointer_interpreter spi_properties chk_u (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .ce_i(ce_i), .bypass_i(bypass_i), .valid_i(valid_i),
  .data_i(data_i), .h2_slot_i(h2_slot_i), .h3_slot_i(h3_slot_i),
  .spe_slot_i(spe_slot_i), .trace_slot_i(trace_slot_i), .valid_o(valid_o),
  .data_o(data_o), .payload_envelope_flag_o(payload_envelope_flag_o),
  .trace_payload_start_flag_o(trace_payload_start_flag_o),
  .ndf_req_o(ndf_req_o), .inc_o(inc_o), .dec_o(dec_o), .ais_o(ais_o));

// file: tb/spi_properties.sv
`timescale 1ns/100ps
module spi_properties (
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       ce_i,
  input wire       bypass_i,
  input wire       valid_i,
  input wire [7:0] data_i,
  input wire       h2_slot_i,
  input wire       h3_slot_i,
  input wire       spe_slot_i,
  input wire       trace_slot_i,
  input wire       valid_o,
  input wire [7:0] data_o,
  input wire       payload_envelope_flag_o,
  input wire       trace_payload_start_flag_o,
  input wire       ndf_req_o,
  input wire       inc_o,
  input wire       dec_o,
  input wire       ais_o
);
  reg [1:0] live_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Marks edges whose output byte was taken after reset with ce high.
  always @(posedge clk_sys_i) begin
    live_q <= {live_q[0], ~rst_i & ce_i};
  end
  // Timing, fill and flag relations of the output byte stream.
  a_valid_delay: assert property (live_q == 2'b11 |-> valid_o == $past(valid_i, 2)) else $error("valid out not two cycles late");
  a_data_delay: assert property (live_q == 2'b11 && valid_o && !ais_o |-> data_o == $past(data_i, 2)) else $error("data out disturbed");
  a_ais_fill: assert property (valid_o && ais_o |-> data_o == 8'hFF) else $error("data not filled in alarm");
  a_ais_quiet: assert property (ais_o |-> !payload_envelope_flag_o && !trace_payload_start_flag_o) else $error("flags in alarm");
  a_bypass_quiet: assert property (bypass_i [*3] |-> !(payload_envelope_flag_o | trace_payload_start_flag_o | ndf_req_o | inc_o | dec_o | ais_o)) else $error("outputs live in bypass");
  a_payload_slot: assert property (live_q == 2'b11 && payload_envelope_flag_o |-> $past(spe_slot_i, 2) || $past(h3_slot_i, 2)) else $error("payload flag off slot");
  a_trace_alone: assert property (live_q == 2'b11 && $past(trace_slot_i, 2) && !$past(spe_slot_i, 2) && !$past(h3_slot_i, 2) |-> !payload_envelope_flag_o) else $error("trace byte flagged payload");
  a_ndf_on_h2: assert property (ndf_req_o |-> valid_o && $past(h2_slot_i, 2)) else $error("new data pulse off pointer");
  a_adjust_h2: assert property (inc_o || dec_o |-> !(inc_o && dec_o) && $past(h2_slot_i, 2)) else $error("bad adjust pulse");
endmodule  // spi_properties
